// ==== dieng_pkg.sv ====
// constants, register map and state encoding for the integration engine
package dieng_pkg;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int ADC_W = 14;
  localparam int ACC_W = 27;
  localparam int LEN_W = 8;
  localparam int CNT_W = 10;
  localparam int TICK_W = 7;
  localparam int ELAPSED_W = 24;
  localparam int FMT_W = 3;
  localparam int NUM_CH = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_FIFO_FMT = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_CH_SEL = 8'h54;
  localparam logic [ADDR_W-1:0] ADDR_CH_PD = 8'h55;
  localparam logic [ADDR_W-1:0] ADDR_DI_EN = 8'h58;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN = 8'h5a;
  localparam logic [ADDR_W-1:0] ADDR_A_RES0 = 8'h64;
  localparam logic [ADDR_W-1:0] ADDR_B_RES0 = 8'h68;
  localparam logic [ADDR_W-1:0] ADDR_A_RES1 = 8'h70;
  localparam logic [ADDR_W-1:0] ADDR_A_RES2 = 8'h74;
  localparam logic [ADDR_W-1:0] ADDR_B_RES1 = 8'h78;
  localparam logic [ADDR_W-1:0] ADDR_B_RES2 = 8'h7c;

  // reset value of every writable register
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // field positions
  localparam int FMT_A_LSB = 2;
  localparam int FMT_B_LSB = 6;
  localparam int SINGLE_CH_A_BIT = 14;
  localparam int SINGLE_CH_B_BIT = 15;
  localparam int PD_LSB = 13;
  localparam int DI_EN_A_BIT = 12;
  localparam int DI_EN_B_BIT = 13;
  localparam int SINGLE_PAIR_A_BIT = 5;
  localparam int SINGLE_PAIR_B_BIT = 6;
  localparam int GAP_EN_BIT = 7;

  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CONV_PERIOD_US = 1;
  localparam int CONV_PERIOD_PS = CONV_PERIOD_US * 1000000;
  localparam int CONV_CYCLES = CONV_PERIOD_PS / CLK_PERIOD_PS;
  localparam int GAP_STEP_PS = 31250;
  localparam int WINDOW_LEAD = 9;

  // window sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LEAD = 7'h02,
    ST_NEG1 = 7'h04,
    ST_GAP = 7'h08,
    ST_POS = 7'h10,
    ST_NEG2 = 7'h20,
    ST_DONE = 7'h40
  } dieng_state_t;

endpackage

// ==== dieng_accum.sv ====
// signed running total and dark total of one integration window
`timescale 1ns/1ps
`default_nettype none
module dieng_accum
  import dieng_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic clr,
  // conversion result with its region sign
  input wire logic smp_valid,
  input wire logic smp_add,
  input wire logic smp_sub,
  input wire logic [ADC_W-1:0] smp_data,
  // totals
  output logic signed [ACC_W-1:0] total,
  output logic [ACC_W-1:0] dark
);

  logic signed [ACC_W-1:0] total_r;
  logic signed [ACC_W-1:0] total_nxt;
  logic [ACC_W-1:0] dark_r;
  logic [ACC_W-1:0] dark_nxt;
  logic [ACC_W-1:0] smp_ext;

  assign smp_ext = {{(ACC_W-ADC_W){1'b0}}, smp_data};

  // add or subtract each tagged conversion
  always_comb begin
    total_nxt = total_r;
    dark_nxt = dark_r;
    if (clr) begin
      total_nxt = '0;
      dark_nxt = '0;
    end else if (smp_valid && smp_add) begin
      total_nxt = total_r + $signed(smp_ext);
    end else if (smp_valid && smp_sub) begin
      total_nxt = total_r - $signed(smp_ext);
      dark_nxt = dark_r + smp_ext;
    end
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      total_r <= '0;
      dark_r <= '0;
    end else begin
      total_r <= total_nxt;
      dark_r <= dark_nxt;
    end
  end

  assign total = total_r;
  assign dark = dark_r;

endmodule
`default_nettype wire

// ==== dieng_engine.sv ====
// digital integration engine: registers, window sequencer, result routing
//
// How it works
// - while enabled, one conversion starts every microsecond across the window.
// - conversions in positive regions are added, in negative regions subtracted.
// - integration mode bypasses the band-pass filter, integrator acts as follower.
// - at window end the total goes to decimation, one sample per slot.
// - the result goes to the FIFO in the format chosen per slot.
// - the final result is also readable from the slot data registers.
// - single-channel bit connects photodiode to one channel, else all four.
// - power-down field bits switch off channels two to four.
// - pattern bit one selects single pair, zero selects double pair.
// - single pair negative region starts at offset plus 9, one width long.
// - positive region follows at once, same length; output is positive minus negative.
// - double pair: negative at offset plus 9, then positive of twice width.
// - second negative region of one width follows the positive region.
// - double pair output adds the middle region and subtracts both outer ones.
// - with proper timing the result rises with illumination.
// - gap enable inserts 31.25 ns steps between negative and positive regions.
// - a dark total of the negative samples is kept and output.
`timescale 1ns/1ps
`default_nettype none
module dieng_engine
  import dieng_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // per-slot timing settings from the timing core
  input wire logic [LEN_W-1:0] window_start_offset_a,
  input wire logic [LEN_W-1:0] window_start_offset_b,
  input wire logic [LEN_W-1:0] region_length_a,
  input wire logic [LEN_W-1:0] region_length_b,
  input wire logic [LEN_W-1:0] region_gap_length_a,
  input wire logic [LEN_W-1:0] region_gap_length_b,
  // time slot start from the timing core
  input wire logic slot_start,
  input wire logic slot_is_b,
  // converter
  output logic adc_start,
  input wire logic adc_valid,
  input wire logic [ADC_W-1:0] adc_data,
  // decimation stage
  output logic decim_valid,
  output logic decim_slot_b,
  output logic [FMT_W-1:0] decim_format,
  output logic signed [ACC_W-1:0] dark_corrected_result,
  output logic [ACC_W-1:0] dark_total,
  // analog front end control
  output logic afe_bpf_bypass,
  output logic afe_integ_follower,
  output logic [NUM_CH-1:0] ch_connect_a,
  output logic [NUM_CH-1:0] ch_connect_b,
  output logic [NUM_CH-1:0] ch_power_en,
  output logic di_busy
);

  //////////////////////////////////////////////////////////////////////////
  // register file

  logic [DATA_W-1:0] fifo_format_config_r, fifo_format_config_nxt;
  logic [DATA_W-1:0] single_channel_select_r, single_channel_select_nxt;
  logic [DATA_W-1:0] channel_power_down_r, channel_power_down_nxt;
  logic [DATA_W-1:0] integration_enable_r, integration_enable_nxt;
  logic [DATA_W-1:0] sampling_pattern_select_r, sampling_pattern_select_nxt;
  logic [DATA_W-1:0] reg_rdata_r, reg_rdata_nxt;
  logic reg_rvalid_r, reg_rvalid_nxt;
  logic [DATA_W-1:0] res_lo_r [2];
  logic [DATA_W-1:0] res_hi_r [2];
  logic [DATA_W-1:0] res_lo_nxt [2];
  logic [DATA_W-1:0] res_hi_nxt [2];

  // host writes and registered read data
  always_comb begin
    fifo_format_config_nxt = fifo_format_config_r;
    single_channel_select_nxt = single_channel_select_r;
    channel_power_down_nxt = channel_power_down_r;
    integration_enable_nxt = integration_enable_r;
    sampling_pattern_select_nxt = sampling_pattern_select_r;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_FIFO_FMT: fifo_format_config_nxt = reg_wdata;
        ADDR_CH_SEL: single_channel_select_nxt = reg_wdata;
        ADDR_CH_PD: channel_power_down_nxt = reg_wdata;
        ADDR_DI_EN: integration_enable_nxt = reg_wdata;
        ADDR_PATTERN: sampling_pattern_select_nxt = reg_wdata;
        default: ;
      endcase
    end
    reg_rvalid_nxt = reg_rd;
    reg_rdata_nxt = reg_rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_FIFO_FMT: reg_rdata_nxt = fifo_format_config_r;
        ADDR_CH_SEL: reg_rdata_nxt = single_channel_select_r;
        ADDR_CH_PD: reg_rdata_nxt = channel_power_down_r;
        ADDR_DI_EN: reg_rdata_nxt = integration_enable_r;
        ADDR_PATTERN: reg_rdata_nxt = sampling_pattern_select_r;
        ADDR_A_RES0: reg_rdata_nxt = res_lo_r[0];
        ADDR_A_RES1: reg_rdata_nxt = res_lo_r[0];
        ADDR_A_RES2: reg_rdata_nxt = res_hi_r[0];
        ADDR_B_RES0: reg_rdata_nxt = res_lo_r[1];
        ADDR_B_RES1: reg_rdata_nxt = res_lo_r[1];
        ADDR_B_RES2: reg_rdata_nxt = res_hi_r[1];
        default: reg_rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fifo_format_config_r <= REG_RESET;
      single_channel_select_r <= REG_RESET;
      channel_power_down_r <= REG_RESET;
      integration_enable_r <= REG_RESET;
      sampling_pattern_select_r <= REG_RESET;
      reg_rdata_r <= '0;
      reg_rvalid_r <= 1'b0;
    end else begin
      fifo_format_config_r <= fifo_format_config_nxt;
      single_channel_select_r <= single_channel_select_nxt;
      channel_power_down_r <= channel_power_down_nxt;
      integration_enable_r <= integration_enable_nxt;
      sampling_pattern_select_r <= sampling_pattern_select_nxt;
      reg_rdata_r <= reg_rdata_nxt;
      reg_rvalid_r <= reg_rvalid_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;

  //////////////////////////////////////////////////////////////////////////
  // channel connection and power

  // channel 1 always stays connected and powered
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      if (ch == 0) begin : g_first
        assign ch_connect_a[ch] = 1'b1;
        assign ch_connect_b[ch] = 1'b1;
        assign ch_power_en[ch] = 1'b1;
      end else begin : g_rest
        assign ch_connect_a[ch] =
          ~single_channel_select_r[SINGLE_CH_A_BIT];
        assign ch_connect_b[ch] =
          ~single_channel_select_r[SINGLE_CH_B_BIT];
        assign ch_power_en[ch] =
          ~channel_power_down_r[PD_LSB+ch-1];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // window sequencer

  dieng_state_t state_r, state_nxt;
  logic slot_b_r, slot_b_nxt;
  logic single_r, single_nxt;
  logic gap_en_r, gap_en_nxt;
  logic [LEN_W-1:0] off_r, off_nxt;
  logic [LEN_W-1:0] width_r, width_nxt;
  logic [LEN_W-1:0] gap_r, gap_nxt;
  logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic [CNT_W-1:0] reg_cnt_r, reg_cnt_nxt;
  logic [ELAPSED_W-1:0] elapsed_r, elapsed_nxt;
  logic pending_r, pending_nxt;
  logic tag_add_r, tag_add_nxt;
  logic tag_sub_r, tag_sub_nxt;
  logic acc_clr;
  logic tick;
  logic running;
  logic slot_en;
  logic [CNT_W-1:0] cur_len;
  logic [CNT_W-1:0] width_eff;
  logic [ELAPSED_W-1:0] gap_limit;
  logic signed [ACC_W-1:0] acc_total;
  logic [ACC_W-1:0] acc_dark;

  assign slot_en = slot_is_b ? integration_enable_r[DI_EN_B_BIT]
                             : integration_enable_r[DI_EN_A_BIT];
  assign running = (state_r == ST_LEAD) || (state_r == ST_NEG1) ||
                   (state_r == ST_POS) || (state_r == ST_NEG2);
  assign tick = running && (tick_cnt_r == '0);
  assign adc_start = tick;
  assign width_eff = (width_r == '0) ? CNT_W'(1) : CNT_W'(width_r);
  assign gap_limit = ELAPSED_W'(CONV_PERIOD_PS) +
                     ELAPSED_W'(gap_r) * ELAPSED_W'(GAP_STEP_PS);

  // length of the region now running, in conversions
  always_comb begin
    case (state_r)
      ST_LEAD: cur_len = CNT_W'(off_r) + CNT_W'(WINDOW_LEAD);
      ST_NEG1: cur_len = width_eff;
      ST_POS: cur_len = single_r ? width_eff
                                 : CNT_W'(width_eff << 1);
      ST_NEG2: cur_len = width_eff;
      default: cur_len = CNT_W'(1);
    endcase
  end

  // next state, counters and conversion tags
  always_comb begin
    state_nxt = state_r;
    slot_b_nxt = slot_b_r;
    single_nxt = single_r;
    gap_en_nxt = gap_en_r;
    off_nxt = off_r;
    width_nxt = width_r;
    gap_nxt = gap_r;
    reg_cnt_nxt = reg_cnt_r;
    elapsed_nxt = '0;
    acc_clr = 1'b0;
    tag_add_nxt = tag_add_r;
    tag_sub_nxt = tag_sub_r;
    pending_nxt = pending_r;
    if (adc_valid) begin
      pending_nxt = 1'b0;
    end
    if (running) begin
      tick_cnt_nxt = (tick_cnt_r == TICK_W'(CONV_CYCLES-1))
                     ? '0 : tick_cnt_r + 1'b1;
    end else begin
      tick_cnt_nxt = '0;
    end
    if (tick) begin
      pending_nxt = 1'b1;
      tag_add_nxt = (state_r == ST_POS);
      tag_sub_nxt = (state_r == ST_NEG1) || (state_r == ST_NEG2);
      reg_cnt_nxt = reg_cnt_r + 1'b1;
    end
    case (state_r)
      ST_IDLE: begin
        if (slot_start && slot_en) begin
          state_nxt = ST_LEAD;
          acc_clr = 1'b1;
          slot_b_nxt = slot_is_b;
          single_nxt = slot_is_b
            ? sampling_pattern_select_r[SINGLE_PAIR_B_BIT]
            : sampling_pattern_select_r[SINGLE_PAIR_A_BIT];
          gap_en_nxt = sampling_pattern_select_r[GAP_EN_BIT];
          off_nxt = slot_is_b ? window_start_offset_b
                              : window_start_offset_a;
          width_nxt = slot_is_b ? region_length_b : region_length_a;
          gap_nxt = slot_is_b ? region_gap_length_b : region_gap_length_a;
          reg_cnt_nxt = '0;
          pending_nxt = 1'b0;
          tag_add_nxt = 1'b0;
          tag_sub_nxt = 1'b0;
        end
      end
      ST_LEAD, ST_NEG1, ST_POS, ST_NEG2: begin
        if (tick && (reg_cnt_r == cur_len - 1'b1)) begin
          reg_cnt_nxt = '0;
          case (state_r)
            ST_LEAD: state_nxt = ST_NEG1;
            ST_NEG1: state_nxt = gap_en_r ? ST_GAP : ST_POS;
            ST_POS: state_nxt = single_r ? ST_DONE : ST_NEG2;
            default: state_nxt = ST_DONE;
          endcase
        end
      end
      ST_GAP: begin
        // one conversion period plus the programmed gap, no conversions
        elapsed_nxt = elapsed_r + ELAPSED_W'(CLK_PERIOD_PS);
        if (elapsed_nxt >= gap_limit) begin
          state_nxt = ST_POS;
        end
      end
      ST_DONE: begin
        if (!pending_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      slot_b_r <= 1'b0;
      single_r <= 1'b0;
      gap_en_r <= 1'b0;
      off_r <= '0;
      width_r <= '0;
      gap_r <= '0;
      tick_cnt_r <= '0;
      reg_cnt_r <= '0;
      elapsed_r <= '0;
      pending_r <= 1'b0;
      tag_add_r <= 1'b0;
      tag_sub_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      slot_b_r <= slot_b_nxt;
      single_r <= single_nxt;
      gap_en_r <= gap_en_nxt;
      off_r <= off_nxt;
      width_r <= width_nxt;
      gap_r <= gap_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      reg_cnt_r <= reg_cnt_nxt;
      elapsed_r <= elapsed_nxt;
      pending_r <= pending_nxt;
      tag_add_r <= tag_add_nxt;
      tag_sub_r <= tag_sub_nxt;
    end
  end

  // positive minus negative keeps the result rising with light
  dieng_accum u_accum (
    .ref_clk(ref_clk),
    .srst(srst),
    .clr(acc_clr),
    .smp_valid(adc_valid && pending_r),
    .smp_add(tag_add_r),
    .smp_sub(tag_sub_r),
    .smp_data(adc_data),
    .total(acc_total),
    .dark(acc_dark)
  );

  //////////////////////////////////////////////////////////////////////////
  // result hand-off

  logic done_now;
  logic decim_valid_r, decim_valid_nxt;
  logic decim_slot_b_r, decim_slot_b_nxt;
  logic [FMT_W-1:0] decim_format_r, decim_format_nxt;
  logic signed [ACC_W-1:0] result_r, result_nxt;
  logic [ACC_W-1:0] dark_r, dark_nxt;

  assign done_now = (state_r == ST_DONE) && !pending_r;

  // one sample per slot window, with that slot's output format
  always_comb begin
    decim_valid_nxt = done_now;
    decim_slot_b_nxt = decim_slot_b_r;
    decim_format_nxt = decim_format_r;
    result_nxt = result_r;
    dark_nxt = dark_r;
    res_lo_nxt = res_lo_r;
    res_hi_nxt = res_hi_r;
    if (done_now) begin
      decim_slot_b_nxt = slot_b_r;
      decim_format_nxt = slot_b_r
        ? fifo_format_config_r[FMT_B_LSB +: FMT_W]
        : fifo_format_config_r[FMT_A_LSB +: FMT_W];
      result_nxt = acc_total;
      dark_nxt = acc_dark;
      res_lo_nxt[slot_b_r] = acc_total[DATA_W-1:0];
      res_hi_nxt[slot_b_r] =
        DATA_W'($signed(acc_total[ACC_W-1:DATA_W]));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      decim_valid_r <= 1'b0;
      decim_slot_b_r <= 1'b0;
      decim_format_r <= '0;
      result_r <= '0;
      dark_r <= '0;
      res_lo_r <= '{default: '0};
      res_hi_r <= '{default: '0};
    end else begin
      decim_valid_r <= decim_valid_nxt;
      decim_slot_b_r <= decim_slot_b_nxt;
      decim_format_r <= decim_format_nxt;
      result_r <= result_nxt;
      dark_r <= dark_nxt;
      res_lo_r <= res_lo_nxt;
      res_hi_r <= res_hi_nxt;
    end
  end

  assign decim_valid = decim_valid_r;
  assign decim_slot_b = decim_slot_b_r;
  assign decim_format = decim_format_r;
  assign dark_corrected_result = result_r;
  assign dark_total = dark_r;

  // analog path setup while a window is open
  assign di_busy = (state_r != ST_IDLE);
  assign afe_bpf_bypass = di_busy;
  assign afe_integ_follower = di_busy;

endmodule
`default_nettype wire

// ==== dieng_engine_properties.sv ====
// assertions on the engine ports
`timescale 1ns/1ps
`default_nettype none
module dieng_checker
  import dieng_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  // window, converter and decimation
  input wire logic slot_start,
  input wire logic slot_is_b,
  input wire logic adc_start,
  input wire logic decim_valid,
  input wire logic decim_slot_b,
  input wire logic [FMT_W-1:0] decim_format,
  input wire logic signed [ACC_W-1:0] dark_corrected_result,
  // front end control
  input wire logic afe_bpf_bypass,
  input wire logic afe_integ_follower,
  input wire logic [NUM_CH-1:0] ch_connect_a,
  input wire logic [NUM_CH-1:0] ch_connect_b,
  input wire logic [NUM_CH-1:0] ch_power_en,
  input wire logic di_busy
);
  logic [DATA_W-1:0] fmt_r, sel_r, pd_r, en_r, pat_r;
  logic [7:0] cnt_r;
  logic run_r, rst_d_r;
  logic en_now;

  ////////////////////////////////////////////////////////////////////////
  // shadow registers and conversion spacing counter
  assign en_now = slot_is_b ? en_r[DI_EN_B_BIT] : en_r[DI_EN_A_BIT];
  always_ff @(posedge ref_clk) begin
    rst_d_r <= srst;
    if (srst) begin
      {fmt_r, sel_r, pd_r, en_r, pat_r} <= '0;
      cnt_r <= 8'h00;
      run_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_FIFO_FMT) fmt_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CH_SEL) sel_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CH_PD) pd_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_DI_EN) en_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_PATTERN) pat_r <= reg_wdata;
      cnt_r <= adc_start ? 8'h01 : (cnt_r == 8'hff ? cnt_r : cnt_r + 8'h01);
      if (adc_start) run_r <= 1'b1;
      else if (decim_valid) run_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // properties; skip the cycle after reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || rst_d_r);

  property p_spacing;
    adc_start && run_r |-> cnt_r == CONV_CYCLES || pat_r[GAP_EN_BIT];
  endproperty
  a_spacing: assert property (p_spacing) else $error("bad spacing");
  property p_idle;
    !di_busy |-> !adc_start;
  endproperty
  a_idle: assert property (p_idle) else $error("idle start");
  property p_go;
    slot_start && !di_busy && !decim_valid && en_now |=> adc_start && di_busy;
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_refuse;
    slot_start && !di_busy && !decim_valid && !en_now |=> !di_busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("slot ran");
  property p_afe;
    adc_start |-> afe_bpf_bypass && afe_integ_follower;
  endproperty
  a_afe: assert property (p_afe) else $error("afe off");
  property p_decim;
    decim_valid |=> !decim_valid && !di_busy;
  endproperty
  a_decim: assert property (p_decim) else $error("double");
  property p_hold;
    !decim_valid |-> $stable(dark_corrected_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_fmt;
    decim_valid |-> decim_format == (decim_slot_b ?
      fmt_r[FMT_B_LSB+:FMT_W] : fmt_r[FMT_A_LSB+:FMT_W]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_conn;
    ch_connect_a == {{3{~sel_r[SINGLE_CH_A_BIT]}}, 1'b1} &&
    ch_connect_b == {{3{~sel_r[SINGLE_CH_B_BIT]}}, 1'b1};
  endproperty
  a_conn: assert property (p_conn) else $error("connect");
  property p_pwr;
    ch_power_en == {~pd_r[PD_LSB+:3], 1'b1};
  endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  property p_unmap;
    reg_rd && reg_addr == 8'h00 |=> reg_rvalid && reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
endmodule

bind dieng_engine dieng_checker u_chk (.ref_clk, .srst, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .slot_start, .slot_is_b,
  .adc_start, .decim_valid, .decim_slot_b, .decim_format,
  .dark_corrected_result, .afe_bpf_bypass, .afe_integ_follower,
  .ch_connect_a, .ch_connect_b, .ch_power_en, .di_busy);
`default_nettype wire

// ==== dieng_adc_model.sv ====
// converter model, answers each start after a latency
`timescale 1ns/1ps
`default_nettype none
module dieng_adc_model
  import dieng_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bench control
  input wire logic restart,
  input wire logic [6:0] lat,
  input wire logic [ADC_W-1:0] base,
  input wire logic [ADC_W-1:0] step,
  // converter pins
  input wire logic adc_start,
  output logic adc_valid,
  output logic [ADC_W-1:0] adc_data
);
  logic [6:0] wait_r;
  logic pend_r;
  logic [ADC_W-1:0] n_r, last_r, cur;

  ////////////////////////////////////////////////////////////////////////
  // ramp data; stale data shows inverted
  assign cur = base + n_r * step;
  always_ff @(posedge ref_clk) begin
    adc_valid <= 1'b0;
    adc_data <= ~last_r;
    if (srst || restart) begin
      n_r <= '0;
      pend_r <= 1'b0;
      last_r <= '0;
    end else if (adc_start) begin
      pend_r <= 1'b1;
      wait_r <= lat;
    end else if (pend_r && wait_r == 7'h00) begin
      pend_r <= 1'b0;
      adc_valid <= 1'b1;
      adc_data <= cur;
      last_r <= cur;
      n_r <= n_r + 1'b1;
    end else if (pend_r) begin
      wait_r <= wait_r - 7'h01;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the engine
`timescale 1ns/1ps
`default_nettype none
module tb
  import dieng_pkg::*;
;
  localparam logic [ADDR_W-1:0] ADDRS [12] = '{ADDR_FIFO_FMT, ADDR_CH_SEL,
    ADDR_CH_PD, ADDR_DI_EN, ADDR_PATTERN, 8'h00, ADDR_A_RES0, ADDR_A_RES1,
    ADDR_A_RES2, ADDR_B_RES0, ADDR_B_RES1, ADDR_B_RES2};
  logic ref_clk, srst, reg_wr, reg_rd, reg_rvalid, slot_start, slot_is_b;
  logic adc_start, adc_valid, decim_valid, decim_slot_b, di_busy, bpf, fol;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd, fmt, v;
  logic [LEN_W-1:0] off_a, off_b, len_a, len_b, gap_a, gap_b;
  logic [ADC_W-1:0] adc_data, base, step;
  logic [6:0] lat;
  logic [FMT_W-1:0] decim_format;
  logic signed [ACC_W-1:0] res, ex;
  logic [ACC_W-1:0] dk, exd;
  logic [NUM_CH-1:0] con_a, con_b, pwr;
  int err_total, checked, seed;

  dieng_engine dut (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .window_start_offset_a(off_a),
    .window_start_offset_b(off_b), .region_length_a(len_a),
    .region_length_b(len_b), .region_gap_length_a(gap_a),
    .region_gap_length_b(gap_b), .slot_start, .slot_is_b, .adc_start,
    .adc_valid, .adc_data, .decim_valid, .decim_slot_b, .decim_format,
    .dark_corrected_result(res), .dark_total(dk), .afe_bpf_bypass(bpf),
    .afe_integ_follower(fol), .ch_connect_a(con_a), .ch_connect_b(con_b),
    .ch_power_en(pwr), .di_busy);
  dieng_adc_model adc (.ref_clk, .srst, .restart(slot_start), .lat, .base,
    .step, .adc_start, .adc_valid, .adc_data);

  ////////////////////////////////////////////////////////////////////////
  // clock, compare, verdict and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [ACC_W-1:0] seen, e);
    checked++;
    if (seen !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, e);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  // register access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(ACC_W'(reg_rvalid), 1);
    d = reg_rdata;
  endtask
  // expected window sums for the ramp
  function automatic void calc(input int off, input int w, input logic sp,
      output logic signed [ACC_W-1:0] r, output logic [ACC_W-1:0] d);
    int j, pw;
    logic [ADC_W-1:0] s;
    if (w == 0) w = 1;
    pw = sp ? w : 2 * w;
    r = '0;
    d = '0;
    for (int i = 0; i < off + 9 + w + pw + (sp ? 0 : w); i++) begin
      j = i - off - 9;
      s = base + ADC_W'(i) * step;
      if (j >= 0 && (j < w || j >= w + pw)) begin
        r -= ACC_W'(s);
        d += ACC_W'(s);
      end else if (j >= w) r += ACC_W'(s);
    end
  endfunction
  task automatic win(input logic sb, input logic [1:0] off,
      input logic [1:0] w, input logic sp, input logic gap);
    int i;
    {base, step} <= 28'($random(seed));
    lat <= 7'($unsigned($random(seed)) % 100);
    fmt = DATA_W'($random(seed));
    if (sb) {off_b, len_b, gap_b} <= {6'h00, off, 6'h00, w, 8'($random(seed))};
    else {off_a, len_a, gap_a} <= {6'h00, off, 6'h00, w, 8'($random(seed))};
    wr(ADDR_PATTERN, {8'h00, gap, sp, sp, 5'h00});
    wr(ADDR_FIFO_FMT, fmt);
    wr(ADDR_DI_EN, 16'h3000);
    calc(off, w, sp, ex, exd);
    @(posedge ref_clk);
    slot_start <= 1'b1;
    slot_is_b <= sb;
    @(posedge ref_clk);
    slot_start <= 1'b0;
    for (i = 0; i < 5000 && decim_valid !== 1'b1; i++) @(posedge ref_clk) #1;
    chk(ACC_W'(decim_valid), 1);
    chk(res, ex);
    chk(dk, exd);
    chk(ACC_W'(decim_slot_b), ACC_W'(sb));
    chk(ACC_W'(decim_format), ACC_W'(sb ? fmt[8:6] : fmt[4:2]));
    for (i = 0; i < 2; i++) begin
      rdr(ADDRS[6 + 3 * int'(sb) + i], rd);
      chk(ACC_W'(rd), ACC_W'(ex[15:0]));
    end
    wr(ADDRS[8 + 3 * int'(sb)], ~rd);
    rdr(ADDRS[8 + 3 * int'(sb)], rd);
    chk(ACC_W'(rd), ACC_W'({{5{ex[26]}}, ex[26:16]}));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'hb6c6baea;
    {err_total, checked} = '0;
    {srst, reg_wr, reg_rd, slot_start, slot_is_b} = 5'b10000;
    {reg_addr, reg_wdata, off_a, off_b, len_a, len_b, gap_a, gap_b} = '0;
    {base, step, lat, fmt} = '0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (ADDRS[k]) begin
      rdr(ADDRS[k], rd);
      chk(ACC_W'(rd), ACC_W'(REG_RESET));
    end
    for (int k = 0; k < 4; k++) begin
      v = k == 0 ? 16'he000 : DATA_W'($random(seed));
      wr(ADDR_CH_SEL, v);
      wr(ADDR_CH_PD, v);
      rdr(ADDR_CH_PD, rd);
      chk(ACC_W'(rd), ACC_W'(v));
      chk(ACC_W'({con_a, con_b}), ACC_W'({{3{~v[14]}}, 1'b1,
        {3{~v[15]}}, 1'b1}));
      chk(ACC_W'(pwr), ACC_W'({~v[15:13], 1'b1}));
    end
    wr(ADDR_DI_EN, 16'h1000);
    @(posedge ref_clk);
    slot_start <= 1'b1;
    slot_is_b <= 1'b1;
    @(posedge ref_clk);
    slot_start <= 1'b0;
    repeat (3) @(posedge ref_clk) #1;
    chk(ACC_W'(di_busy), 0);
    win(1'b0, 2'd0, 2'd0, 1'b1, 1'b0);
    win(1'b1, 2'd3, 2'd3, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      v = DATA_W'($random(seed));
      win(v[0], v[2:1], v[4:3], v[5], v[6]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
